// [hdl/gpioe_top.sv]
// gpio unit with edge interrupts, dma events and apb registers
`timescale 1ns/10ps
`default_nettype none
module gpioe_top (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [103:0] pin_in,
   output logic [103:0] pin_out,
   output logic [103:0] pin_oe_n,
   input wire logic power_sleep_manager_lowpower,
   output logic [9:0] pin_irq,
   output logic [6:0] bank_irq,
   output logic [9:0] pin_dma_event,
   output logic [6:0] bank_dma_event
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [127:0] dir_reg, dir_next;
   logic [127:0] out_reg, out_next;
   logic [127:0] rise_reg, rise_next;
   logic [127:0] fall_reg, fall_next;
   logic [127:0] pend_reg, pend_next;
   logic [127:0] in_reg, in_next;
   logic [6:0] bank_en_reg, bank_en_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [103:0] drive_reg, drive_next;
   logic [103:0] oe_n_reg, oe_n_next;
   logic [9:0] pin_irq_reg, pin_irq_next;
   logic [6:0] bank_irq_reg, bank_irq_next;
   logic [9:0] pin_dma_reg, pin_dma_next;
   logic [6:0] bank_dma_reg, bank_dma_next;
   logic [127:0] pin_state;
   logic [127:0] edge_event;
   logic run;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic hit_id, hit_bank_en, hit_group;
   logic [1:0] grp;
   logic [3:0] idx;
   logic mapped;
   logic wr_strobe, rd_setup;

   always_comb begin
      logic [11:0] rel;
      rel = 12'h000;
      hit_id = (paddr == gpioe_pkg::OFS_ID);
      hit_bank_en = (paddr == gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE);
      hit_group = 1'b0;
      grp = 2'h0;
      idx = 4'h0;
      for (int g = 0; g < gpioe_pkg::GROUP_COUNT; g++) begin
         rel = paddr - (gpioe_pkg::OFS_GROUP_BASE + 12'(g) * gpioe_pkg::OFS_GROUP_STRIDE);
         if (paddr >= gpioe_pkg::OFS_GROUP_BASE + 12'(g) * gpioe_pkg::OFS_GROUP_STRIDE &&
             rel < gpioe_pkg::OFS_GROUP_STRIDE && rel[1:0] == 2'h0) begin
            hit_group = 1'b1;
            grp = 2'(g);
            idx = rel[5:2];
         end
      end
      mapped = hit_id | hit_bank_en | hit_group;
   end

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_strobe = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling and sampled state
   always_comb begin
      in_next = {24'h000000, pin_in};
      // direction picks driven or sampled level
      pin_state = ((~dir_reg & out_reg) | (dir_reg & in_reg)) & gpioe_pkg::PIN_MASK;
      // events stop while in low power
      run = ~power_sleep_manager_lowpower;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one detector per bank of sixteen pins
   for (genvar b = 0; b < gpioe_pkg::BANK_COUNT; b++) begin : g_bank
      gpioe_bank_edge u_edge (
         .mclk(mclk),
         .arst_n(arst_n),
         .pin_state(pin_state[16*b +: 16]),
         .rise_en(rise_reg[16*b +: 16]),
         .fall_en(fall_reg[16*b +: 16]),
         .bank_en(bank_en_reg[b]),
         .run(run),
         .edge_event(edge_event[16*b +: 16])
      );
   end
   assign edge_event[127:112] = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // register writes and pending flags
   always_comb begin
      logic [127:0] wvec;
      logic [127:0] gmask;
      wvec = 128'h0;
      gmask = 128'h0;
      dir_next = dir_reg;
      out_next = out_reg;
      rise_next = rise_reg;
      fall_next = fall_reg;
      bank_en_next = bank_en_reg;
      wvec[32*grp +: 32] = pwdata;
      gmask[32*grp +: 32] = 32'hFFFFFFFF;
      wvec = wvec & gpioe_pkg::PIN_MASK;
      gmask = gmask & gpioe_pkg::PIN_MASK;
      if (wr_strobe && hit_bank_en) begin
         bank_en_next = pwdata[6:0];
      end
      if (wr_strobe && hit_group) begin
         unique case (idx)
            gpioe_pkg::IDX_DIR: dir_next = (dir_reg & ~gmask) | wvec;
            gpioe_pkg::IDX_OUT_DATA: out_next = (out_reg & ~gmask) | wvec;
            gpioe_pkg::IDX_SET_DATA: out_next = out_reg | wvec;
            gpioe_pkg::IDX_CLR_DATA: out_next = out_reg & ~wvec;
            gpioe_pkg::IDX_RISE_SET: rise_next = rise_reg | wvec;
            gpioe_pkg::IDX_RISE_CLEAR: rise_next = rise_reg & ~wvec;
            gpioe_pkg::IDX_FALL_SET: fall_next = fall_reg | wvec;
            gpioe_pkg::IDX_FALL_CLEAR: fall_next = fall_reg & ~wvec;
            default: ;
         endcase
      end
      // write one clears, a new edge wins over the clear
      if (wr_strobe && hit_group && idx == gpioe_pkg::IDX_PENDING) begin
         pend_next = (pend_reg & ~wvec) | edge_event;
      end else begin
         pend_next = pend_reg | edge_event;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle
   always_comb begin
      logic [127:0] src;
      src = 128'h0;
      prdata_next = prdata_reg;
      if (rd_setup) begin
         unique case (idx)
            gpioe_pkg::IDX_DIR: src = dir_reg;
            gpioe_pkg::IDX_OUT_DATA: src = out_reg;
            gpioe_pkg::IDX_SET_DATA: src = out_reg;
            gpioe_pkg::IDX_CLR_DATA: src = out_reg;
            gpioe_pkg::IDX_IN_DATA: src = pin_state;
            gpioe_pkg::IDX_RISE_SET: src = rise_reg;
            gpioe_pkg::IDX_RISE_CLEAR: src = rise_reg;
            gpioe_pkg::IDX_FALL_SET: src = fall_reg;
            gpioe_pkg::IDX_FALL_CLEAR: src = fall_reg;
            gpioe_pkg::IDX_PENDING: src = pend_reg;
            default: src = 128'h0;
         endcase
         src = src & gpioe_pkg::PIN_MASK;
         if (hit_id) begin
            prdata_next = gpioe_pkg::ID_VALUE;
         end else if (hit_bank_en) begin
            prdata_next = {25'h0000000, bank_en_reg};
         end else if (hit_group) begin
            prdata_next = src[32*grp +: 32];
         end else begin
            prdata_next = 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive, interrupt lines and dma events
   always_comb begin
      drive_next = drive_reg;
      oe_n_next = oe_n_reg;
      // pin drive frozen during low power
      if (run) begin
         drive_next = out_reg[103:0];
         oe_n_next = dir_reg[103:0];
      end
      // dedicated lines, silent in low power
      pin_irq_next = run ? pend_reg[9:0] : 10'h000;
      for (int b = 0; b < gpioe_pkg::BANK_COUNT; b++) begin
         // bank line from its pending flags and enable
         bank_irq_next[b] = run & bank_en_reg[b] & (|pend_reg[16*b +: 16]);
         bank_dma_next[b] = |edge_event[16*b +: 16];
      end
      pin_dma_next = edge_event[9:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // hardware reset only; no direction or halt term
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dir_reg <= gpioe_pkg::RST_DIR;
         out_reg <= gpioe_pkg::RST_ZERO;
         rise_reg <= gpioe_pkg::RST_ZERO;
         fall_reg <= gpioe_pkg::RST_ZERO;
         pend_reg <= gpioe_pkg::RST_ZERO;
         in_reg <= gpioe_pkg::RST_ZERO;
         bank_en_reg <= gpioe_pkg::RST_BANK_EN;
         prdata_reg <= 32'h00000000;
         drive_reg <= 104'h0;
         oe_n_reg <= {104{1'b1}};
         pin_irq_reg <= 10'h000;
         bank_irq_reg <= 7'h00;
         pin_dma_reg <= 10'h000;
         bank_dma_reg <= 7'h00;
      end else begin
         dir_reg <= dir_next;
         out_reg <= out_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         pend_reg <= pend_next;
         in_reg <= in_next;
         bank_en_reg <= bank_en_next;
         prdata_reg <= prdata_next;
         drive_reg <= drive_next;
         oe_n_reg <= oe_n_next;
         pin_irq_reg <= pin_irq_next;
         bank_irq_reg <= bank_irq_next;
         pin_dma_reg <= pin_dma_next;
         bank_dma_reg <= bank_dma_next;
      end
   end

   assign prdata = prdata_reg;
   assign pin_out = drive_reg;
   assign pin_oe_n = oe_n_reg;
   assign pin_irq = pin_irq_reg;
   assign bank_irq = bank_irq_reg;
   assign pin_dma_event = pin_dma_reg;
   assign bank_dma_event = bank_dma_reg;
endmodule // gpioe_top
`default_nettype wire

// [hdl/gpioe_pkg.sv]
// constants shared by the edge interrupt and event unit
package gpioe_pkg;
   // sizes
   localparam int PIN_COUNT = 104;
   localparam int VEC_W = 128;
   localparam int BANK_COUNT = 7;
   localparam int BANK_W = 16;
   localparam int PIN_IRQ_COUNT = 10;
   localparam int GROUP_COUNT = 4;
   localparam int GROUP_REGS = 10;
   localparam int ADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] OFS_ID = 12'h000;
   localparam logic [11:0] OFS_BANK_INTERRUPT_ENABLE = 12'h008;
   localparam logic [11:0] OFS_GROUP_BASE = 12'h010;
   localparam logic [11:0] OFS_GROUP_STRIDE = 12'h028;
   // register index inside a bank-pair group
   localparam logic [3:0] IDX_DIR = 4'h0;
   localparam logic [3:0] IDX_OUT_DATA = 4'h1;
   localparam logic [3:0] IDX_SET_DATA = 4'h2;
   localparam logic [3:0] IDX_CLR_DATA = 4'h3;
   localparam logic [3:0] IDX_IN_DATA = 4'h4;
   localparam logic [3:0] IDX_RISE_SET = 4'h5;
   localparam logic [3:0] IDX_RISE_CLEAR = 4'h6;
   localparam logic [3:0] IDX_FALL_SET = 4'h7;
   localparam logic [3:0] IDX_FALL_CLEAR = 4'h8;
   localparam logic [3:0] IDX_PENDING = 4'h9;
   // reset values
   localparam logic [127:0] RST_DIR = {128{1'b1}};
   localparam logic [127:0] RST_ZERO = 128'h0;
   localparam logic [6:0] RST_BANK_EN = 7'h00;
   localparam logic [127:0] PIN_MASK = {24'h000000, {104{1'b1}}};
   // identification word, value arbitrary
   localparam logic [31:0] ID_VALUE = 32'h00A5A501;
   // host interrupt numbers of the lines
   localparam int IRQ_NUM_PIN0 = 44;
   localparam int IRQ_NUM_PIN9 = 53;
   localparam int IRQ_NUM_BANK0 = 54;
   localparam int IRQ_NUM_BANK6 = 60;
   // dma event numbers of the lines
   localparam int DMA_NUM_PIN0 = 32;
   localparam int DMA_NUM_PIN7 = 39;
   localparam int DMA_NUM_PIN8 = 47;
   localparam int DMA_NUM_PIN9 = 25;
   localparam int DMA_NUM_BANK0 = 40;
   localparam int DMA_NUM_BANK6 = 46;
endpackage

// [hdl/gpioe_bank_edge.sv]
// edge detector for one bank of sixteen pins
`timescale 1ns/10ps
`default_nettype none
module gpioe_bank_edge (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [15:0] pin_state,
   input wire logic [15:0] rise_en,
   input wire logic [15:0] fall_en,
   input wire logic bank_en,
   input wire logic run,
   output logic [15:0] edge_event
);
   logic [15:0] prev_reg;
   logic [15:0] prev_next;

   // previous sample always follows, so leaving low power gives no phantom edge
   always_comb begin
      prev_next = pin_state;
      edge_event = {16{run & bank_en}} &
                   ((pin_state & ~prev_reg & rise_en) | (~pin_state & prev_reg & fall_en));
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prev_reg <= 16'h0000;
      end else begin
         prev_reg <= prev_next;
      end
   end
endmodule // gpioe_bank_edge
`default_nettype wire

// [test/gpioe_checker.sv]
// assertion checker for the gpio edge interrupt unit
`timescale 1ns/10ps
`default_nettype none
module gpioe_checker (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   input wire logic [103:0] pin_in,
   input wire logic [103:0] pin_out,
   input wire logic [103:0] pin_oe_n,
   input wire logic power_sleep_manager_lowpower,
   input wire logic [9:0] pin_irq,
   input wire logic [6:0] bank_irq,
   input wire logic [9:0] pin_dma_event,
   input wire logic [6:0] bank_dma_event
);
   logic lp;
   logic wr;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // short names keep the properties readable
   assign lp = power_sleep_manager_lowpower;
   assign wr = psel & penable & pwrite;
   ////////////////////////////////////////////////////////////////////////////////
   AST_LP_IRQ_OFF: assert property (lp && $past(lp) |-> pin_irq == 10'h000 && bank_irq == 7'h00)
      else $error("irq line high in low power");
   AST_LP_DMA_OFF: assert property (lp |=> pin_dma_event == 10'h000 && bank_dma_event == 7'h00)
      else $error("dma pulse in low power");
   AST_LP_PIN_HOLD: assert property (lp && $past(lp) |-> $stable(pin_out) && $stable(pin_oe_n))
      else $error("pin moved in low power");
   AST_PIN_EVT_IRQ: assert property ((|pin_dma_event) |=> lp || (bank_irq[0]
      && (pin_irq & $past(pin_dma_event)) == $past(pin_dma_event)))
      else $error("pin event did not raise its lines");
   AST_BANK_EVT_IRQ: assert property ((|bank_dma_event) |=> lp
      || (bank_irq & $past(bank_dma_event)) == $past(bank_dma_event))
      else $error("bank event did not raise bank line");
   // exit from low power restores lines without a new event
   AST_IRQ_NEEDS_EVENT: assert property (!$past(lp, 1) && !$past(lp, 2) && !$past(lp, 3)
      |-> (pin_irq & ~$past(pin_irq) & ~$past(pin_dma_event)) == 10'h000)
      else $error("pin irq rose without event");
   AST_PIN_IN_BANK0: assert property ((|pin_dma_event) |-> bank_dma_event[0])
      else $error("pin event outside bank zero");
   AST_NO_CAUSE_NO_EVENT: assert property ((!wr && $stable(pin_in)) [*4] |-> bank_dma_event == 7'h00)
      else $error("event without pin change");
   COV_PIN_EVT: cover property (|pin_dma_event);
   COV_BANK_IRQ: cover property (|bank_irq);
   COV_REFUSED: cover property (pslverr);
endmodule // gpioe_checker
bind gpioe_top gpioe_checker u_gpioe_checker (.mclk(mclk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .power_sleep_manager_lowpower(power_sleep_manager_lowpower),
   .pin_irq(pin_irq), .bank_irq(bank_irq), .pin_dma_event(pin_dma_event),
   .bank_dma_event(bank_dma_event));
`default_nettype wire

// [test/gpioe_host_model.sv]
// interrupt and dma controller stand-in that tallies requests
`timescale 1ns/10ps
`default_nettype none
module gpioe_host_model (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [9:0] pin_irq,
   input wire logic [6:0] bank_irq,
   input wire logic [9:0] pin_dma_event,
   input wire logic [6:0] bank_dma_event,
   output var int dma_seen,
   output var int top_irq
);
   // dedicated dma lines
   // every line is its own request, so pulses are counted per line
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dma_seen <= 0;
      end else begin
         dma_seen <= dma_seen + $countones({pin_dma_event, bank_dma_event});
      end
   end
   // host numbering
   // highest active host number wins, as a priority controller would serve it
   always_comb begin
      top_irq = 0;
      for (int i = 0; i < 10; i++) begin
         if (pin_irq[i]) begin
            top_irq = gpioe_pkg::IRQ_NUM_PIN0 + i;
         end
      end
      for (int n = 0; n < 7; n++) begin
         if (bank_irq[n]) begin
            top_irq = gpioe_pkg::IRQ_NUM_BANK0 + n;
         end
      end
   end
endmodule // gpioe_host_model
`default_nettype wire

// [test/tb_gpioe_top.sv]
// self-checking bench for the gpio edge interrupt unit
`timescale 1ns/10ps
`default_nettype none
module tb_gpioe_top;
   logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lp = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err;
   logic [103:0] pin_in = 104'h0, pin_out, pin_oe_n;
   logic [9:0] pin_irq, pin_dma_event;
   logic [6:0] bank_irq, bank_dma_event;
   int n_mismatch = 0, checks = 0, cyc = 0, seed = 32'h3CA5, p, b, k, d0, top_irq, dma_seen;
   always #50 mclk = ~mclk;
   gpioe_top u_gpioe_top (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .power_sleep_manager_lowpower(lp), .pin_irq(pin_irq), .bank_irq(bank_irq),
      .pin_dma_event(pin_dma_event), .bank_dma_event(bank_dma_event));
   gpioe_host_model u_gpioe_host_model (.mclk(mclk), .arst_n(arst_n), .pin_irq(pin_irq),
      .bank_irq(bank_irq), .pin_dma_event(pin_dma_event), .bank_dma_event(bank_dma_event),
      .dma_seen(dma_seen), .top_irq(top_irq));
   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; the extra edge at the end keeps back-to-back calls race free
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // edge reaches pending and the dma lines on the second edge after the pin change, irq lines one later
   task drive_pin(input logic v);
      pin_in[p] <= v;
      repeat (4) @(posedge mclk);
   endtask
   function logic [11:0] ra(input int pin, input logic [3:0] ix);
      return gpioe_pkg::OFS_GROUP_BASE + gpioe_pkg::OFS_GROUP_STRIDE * 12'(pin / 32)
         + {6'h00, ix, 2'h0};
   endfunction
   function logic [31:0] bit_of(input int pin);
      return 32'h1 << (pin % 32);
   endfunction
   function int exp_dma(input int pin);
      return (pin < 10) ? 2 : 1;
   endfunction
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      apb(1'b0, gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE, 32'h0);
      chk("bank enable reset", 32'h0, q);
      apb(1'b0, gpioe_pkg::OFS_ID, 32'h0);
      chk("id word", gpioe_pkg::ID_VALUE, q);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, q);
      apb(1'b1, gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE, 32'h7F);
      apb(1'b0, gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE, 32'h0);
      chk("bank enable readback", 32'h7F, q);
      // all four modes, corner pins first
      for (k = 0; k < 12; k++) begin
         p = (k == 0) ? 103 : (k == 1) ? 9 : {$random(seed)} % 104;
         b = p / 16;
         apb(1'b1, ra(p, k[0] ? gpioe_pkg::IDX_RISE_SET : gpioe_pkg::IDX_RISE_CLEAR), bit_of(p));
         apb(1'b1, ra(p, k[1] ? gpioe_pkg::IDX_FALL_SET : gpioe_pkg::IDX_FALL_CLEAR), bit_of(p));
         d0 = dma_seen;
         drive_pin(1'b1);
         apb(1'b0, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
         chk("rise pending", k[0] ? bit_of(p) : 32'h0, q & bit_of(p));
         chk("dma count", k[0] ? exp_dma(p) : 0, dma_seen - d0);
         if (k[0]) chk("host irq", gpioe_pkg::IRQ_NUM_BANK0 + b, top_irq);
         apb(1'b1, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
         apb(1'b0, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
         chk("pending kept", k[0] ? bit_of(p) : 32'h0, q & bit_of(p));
         // service and clear the pending flag of pin p
         apb(1'b1, ra(p, gpioe_pkg::IDX_PENDING), bit_of(p));
         drive_pin(1'b0);
         apb(1'b0, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
         chk("fall pending", k[1] ? bit_of(p) : 32'h0, q & bit_of(p));
         apb(1'b1, ra(p, gpioe_pkg::IDX_PENDING), bit_of(p));
         apb(1'b0, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
         chk("pending cleared", 32'h0, q & bit_of(p));
      end
      $display("edge mode test finished");
      p = {$random(seed)} % 104;
      b = p / 16;
      apb(1'b1, ra(p, gpioe_pkg::IDX_RISE_SET), bit_of(p));
      apb(1'b1, gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE, 32'h7F & ~(32'h1 << b));
      drive_pin(1'b1);
      chk("bank irq off", 32'h0, {31'h0, bank_irq[b]});
      apb(1'b0, ra(p, gpioe_pkg::IDX_PENDING), 32'h0);
      chk("gated pending", 32'h0, q & bit_of(p));
      drive_pin(1'b0);
      apb(1'b1, gpioe_pkg::OFS_BANK_INTERRUPT_ENABLE, 32'h7F);
      $display("bank gate test finished");
      // output pin makes its own edge
      p = 5;
      apb(1'b1, ra(p, gpioe_pkg::IDX_RISE_SET), bit_of(p));
      apb(1'b1, ra(p, gpioe_pkg::IDX_DIR), ~bit_of(p));
      apb(1'b1, ra(p, gpioe_pkg::IDX_OUT_DATA), bit_of(p));
      repeat (3) @(posedge mclk);
      chk("output driven", 32'h1, {30'h0, pin_oe_n[p], pin_out[p]});
      apb(1'b0, ra(p, gpioe_pkg::IDX_IN_DATA), 32'h0);
      chk("sampled output", bit_of(p), q & bit_of(p));
      chk("output edge irq", 32'h20, {22'h0, pin_irq});
      $display("output pin test finished");
      // low power freezes pins and silences the irq lines
      lp <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("irq in low power", 32'h0, {15'h0, bank_irq, pin_irq});
      apb(1'b1, ra(p, gpioe_pkg::IDX_CLR_DATA), bit_of(p));
      repeat (3) @(posedge mclk);
      chk("held output", 32'h1, {31'h0, pin_out[p]});
      lp <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("output after wake", 32'h0, {31'h0, pin_out[p]});
      chk("irq after wake", 32'h1, {31'h0, pin_irq[5]});
      $display("low power test finished");
      wrap_up;
   end
endmodule // tb_gpioe_top
`default_nettype wire
